// ===== adc_serial_register_port_tb.sv
`timescale 1ns/1ps
module adc_serial_register_port_tb;
    import adcsp_pkg::*;
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        result_new = 1'b0;
    logic        update_soon = 1'b0;
    logic [15:0] result_word = 16'h0000;
    logic        sclk_pin, din_pin, cs_n_pin, dout_o, dout_oe, result_ready_n;
    logic        clock_halve, mclk_en, cal_start, filter_sync, m1, m2, standby;
    logic [1:0]  active_channel;
    logic [7:0]  setup_reg, clock_reg, test_reg;
    logic [23:0] offset_cal, gain_cal, rd;
    wire         sdo;
    int          n_mismatch = 0;
    int          n_compared = 0;
    int          cyc = 0;
    int          oe_cnt = 0;
    int          cal_cnt = 0;

    // The shared data line has a pull-up, so a released output reads high.
    assign sdo = (dout_oe === 1'b1) ? dout_o : 1'b1;

    always #4 sys_clk = ~sys_clk;

    adcsp_serial_port u_adcsp_serial_port (.sys_clk(sys_clk), .srst(srst),
        .sclk_pin(sclk_pin), .din_pin(din_pin), .cs_n_pin(cs_n_pin), .dout_o(dout_o),
        .dout_oe(dout_oe), .result_ready_n(result_ready_n), .result_new(result_new),
        .update_soon(update_soon), .result_word(result_word), .clock_halve(clock_halve),
        .mclk_en(mclk_en), .cal_start(cal_start), .filter_sync(filter_sync),
        .active_channel(active_channel), .standby(standby), .setup_reg(setup_reg),
        .clock_reg(clock_reg), .test_reg(test_reg), .offset_cal(offset_cal),
        .gain_cal(gain_cal));

    adcsp_host_model u_adcsp_host_model (.sys_clk(sys_clk), .sdo(sdo), .sclk_pin(sclk_pin),
        .din_pin(din_pin), .cs_n_pin(cs_n_pin));

    // Event counters, plus a ceiling well above the roughly 3200 cycles the run needs.
    always @(posedge sys_clk) begin
        cyc++;
        if (dout_oe === 1'b1) oe_cnt++;
        if (cal_start === 1'b1) cal_cnt++;
        if (cyc == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task automatic chk(input string nm, input logic [23:0] got, input logic [23:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic new_result(input logic [15:0] w);
        @(negedge sys_clk);
        result_new = 1'b1;
        result_word = w;
        @(negedge sys_clk);
        result_new = 1'b0;
        repeat (2) @(negedge sys_clk);
    endtask

    task automatic t_reset();
        chk("ready_n", result_ready_n, 24'h1);
        chk("oe", dout_oe, 24'h0);
        chk("setup", setup_reg, 24'h01);
        chk("offset", offset_cal, 24'h800000);
        chk("gain", gain_cal, 24'h400000);
    endtask

    // One unbroken 16-clock transfer: command then clock byte, no output meanwhile.
    task automatic t_clock_write();
        oe_cnt = 0;
        u_adcsp_host_model.xfer({8'h00, CMD_CLOCK_WR, CLOCK_EX}, 16, rd);
        chk("clock", clock_reg, 24'h18);
        chk("halve", clock_halve, 24'h1);
        chk("chan", active_channel, 24'h0);
        chk("oe_write", oe_cnt, 24'h0);
        @(negedge sys_clk) m1 = mclk_en;
        @(negedge sys_clk) m2 = mclk_en;
        chk("mclk_toggle", m1 ^ m2, 24'h1);
    endtask

    // A long run of ones first, then a setup write that must still land as a command.
    task automatic t_setup_write();
        u_adcsp_host_model.xfer(24'hFFFFFF, 24, rd);
        u_adcsp_host_model.xfer(24'hFFFFFF, 16, rd);
        cal_cnt = 0;
        u_adcsp_host_model.xfer({8'h00, CMD_SETUP_WR, SETUP_EX}, 16, rd);
        chk("setup", setup_reg, 24'h40);
        chk("cal_pulse", cal_cnt, 24'h1);
        chk("filter_sync", filter_sync, 24'h0);
        chk("clock_kept", clock_reg, 24'h18);
    endtask

    // Result read with ones on the data input, which the read must ignore.
    task automatic t_data_read();
        new_result(16'hA53C);
        chk("ready_low", result_ready_n, 24'h0);
        u_adcsp_host_model.xfer({16'h0000, CMD_DATA_RD}, 8, rd);
        u_adcsp_host_model.xfer(24'hFFFFFF, 16, rd);
        chk("data", rd, 24'h00A53C);
        repeat (3) @(negedge sys_clk);
        chk("ready_high", result_ready_n, 24'h1);
        chk("oe_off", dout_oe, 24'h0);
    endtask

    // Status bit read through the communications register, then an update warning.
    task automatic t_comm_read();
        new_result(16'h0001);
        u_adcsp_host_model.xfer(24'h000008, 8, rd);
        u_adcsp_host_model.xfer(24'h000000, 8, rd);
        chk("comm", rd, 24'h000008);
        @(negedge sys_clk) update_soon = 1'b1;
        @(negedge sys_clk) update_soon = 1'b0;
        repeat (2) @(negedge sys_clk);
        chk("ready_upd", result_ready_n, 24'h1);
        u_adcsp_host_model.xfer(24'h000008, 8, rd);
        u_adcsp_host_model.xfer(24'h000000, 8, rd);
        chk("comm_idle", rd, 24'h000088);
    endtask

    // Wide write split into bytes, with select lifted between them.
    task automatic t_offset_write();
        u_adcsp_host_model.xfer(24'h000060, 8, rd);
        for (int b = 0; b < 3; b++) begin
            u_adcsp_host_model.sel(1'b1);
            u_adcsp_host_model.sel(1'b0);
            u_adcsp_host_model.xfer(24'h000012 + 24'(b * 8'h22), 8, rd);
        end
        repeat (3) @(negedge sys_clk);
        chk("offset", offset_cal, 24'h123456);
        u_adcsp_host_model.xfer(24'h000068, 8, rd);
        u_adcsp_host_model.xfer(24'h000000, 24, rd);
        chk("offset_rd", rd, 24'h123456);
    endtask

    // Test register write with standby and channel bits set, then a 24-bit gain write.
    task automatic t_misc_write();
        u_adcsp_host_model.xfer({8'h00, 8'h45, 8'hA5}, 16, rd);
        chk("test", test_reg, 24'hA5);
        chk("standby", standby, 24'h1);
        chk("chan1", active_channel, 24'h1);
        u_adcsp_host_model.xfer(24'h000070, 8, rd);
        u_adcsp_host_model.xfer(24'h654321, 24, rd);
        chk("gain", gain_cal, 24'h654321);
        chk("standby_off", standby, 24'h0);
    endtask

    initial begin
        repeat (12) @(negedge sys_clk);
        srst = 1'b0;
        repeat (4) @(negedge sys_clk);
        t_reset();
        t_clock_write();
        t_setup_write();
        t_data_read();
        t_comm_read();
        t_offset_write();
        t_misc_write();
        tally_and_finish();
    end
endmodule

// ===== adcsp_host_model.sv
`timescale 1ns/1ps
// Host serial master that clocks the port and reads back whatever sits on the data-out line.
module adcsp_host_model (
    input  wire logic sys_clk,
    input  wire logic sdo,
    output logic      sclk_pin,
    output logic      din_pin,
    output logic      cs_n_pin
);
    initial begin
        sclk_pin = 1'b1;
        din_pin  = 1'b1;
        cs_n_pin = 1'b0;
    end

    // most significant first.
    // Data changes on the falling edge and is sampled on the rising one.
    // Half periods of six cycles low and seven high leave room for the synchronisers.
    task automatic xfer(input logic [23:0] wd, input int n, output logic [23:0] rd);
        rd = 24'h000000;
        for (int i = n - 1; i >= 0; i--) begin
            @(negedge sys_clk);
            sclk_pin = 1'b0;
            din_pin  = wd[i];
            repeat (6) @(negedge sys_clk);
            sclk_pin = 1'b1;
            rd = {rd[22:0], sdo};
            repeat (6) @(negedge sys_clk);
        end
    endtask

    // Select changes only while the clock idles high.
    task automatic sel(input logic v);
        @(negedge sys_clk);
        cs_n_pin = v;
        repeat (2) @(negedge sys_clk);
    endtask
endmodule

// ===== adcsp_if.sv
`timescale 1ns/1ps
interface adcsp_if;
    logic sclk_rise;
    logic sclk_fall;
    logic din_s;
    logic cs_n_s;
    logic data_read;
    logic result_new;
    logic update_soon;
    logic ready_n;

    modport pin_mp (output sclk_rise, output sclk_fall, output din_s, output cs_n_s);
    modport rdy_mp (input data_read, input result_new, input update_soon, output ready_n);
endinterface

// ===== adcsp_pin_sync.sv
`timescale 1ns/1ps
module adcsp_pin_sync (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic sclk_pin,
    input  wire logic din_pin,
    input  wire logic cs_n_pin,
    adcsp_if.pin_mp   pins
);
    import adcsp_pkg::*;

    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic       sclk_old_q;

    // Two stages per pin; the serial clock idles high, so both reset high.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            meta_q     <= 3'h7;
            sync_q     <= 3'h7;
            sclk_old_q <= 1'b1;
        end else begin
            meta_q     <= {cs_n_pin, din_pin, sclk_pin};
            sync_q     <= meta_q;
            sclk_old_q <= sync_q[0];
        end
    end

    // Edges are taken from the second stage only.
    assign pins.sclk_rise = sync_q[0] & ~sclk_old_q;
    assign pins.sclk_fall = ~sync_q[0] & sclk_old_q;
    assign pins.din_s     = sync_q[1];
    assign pins.cs_n_s    = sync_q[2];
endmodule

// ===== adcsp_pkg.sv
package adcsp_pkg;

    // Widths of the shift path and of the register classes.
    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned DATA_W  = 16;
    localparam int unsigned CAL_W   = 24;
    localparam int unsigned SHIFT_W = 24;

    // Bit counts of one register access.
    localparam logic [4:0] BITS_BYTE = 5'h08;
    localparam logic [4:0] BITS_DATA = 5'h10;
    localparam logic [4:0] BITS_CAL  = 5'h18;

    // Register select codes carried in the communications byte.
    localparam logic [2:0] RS_COMM  = 3'h0;
    localparam logic [2:0] RS_SETUP = 3'h1;
    localparam logic [2:0] RS_CLOCK = 3'h2;
    localparam logic [2:0] RS_DATA  = 3'h3;
    localparam logic [2:0] RS_TEST  = 3'h4;
    localparam logic [2:0] RS_NOP   = 3'h5;
    localparam logic [2:0] RS_OFFS  = 3'h6;
    localparam logic [2:0] RS_GAIN  = 3'h7;

    // Communications byte fields.
    localparam int unsigned COMM_ZERO_BIT = 7;
    localparam int unsigned COMM_RS_LSB   = 4;
    localparam int unsigned COMM_RW_BIT   = 3;
    localparam int unsigned COMM_STBY_BIT = 2;
    localparam int unsigned COMM_CH_LSB   = 0;

    // Clock and setup register fields.
    localparam int unsigned CLK_HALVE_BIT   = 3;
    localparam int unsigned SETUP_MODE_LSB  = 6;
    localparam int unsigned SETUP_FILTER_SYNC_BIT = 0;
    localparam logic [1:0]  MODE_NORMAL     = 2'h0;
    localparam logic [1:0]  MODE_SELF_CAL   = 2'h1;

    // Reset values.
    localparam logic [7:0]  SETUP_RST = 8'h01;
    localparam logic [7:0]  CLOCK_RST = 8'h00;
    localparam logic [7:0]  TEST_RST  = 8'h00;
    localparam logic [23:0] OFFS_RST  = 24'h800000;
    localparam logic [23:0] GAIN_RST  = 24'h400000;
    localparam logic [15:0] DATA_RST  = 16'h0000;

    // A run of this many ones on the data input resynchronises the port.
    localparam int unsigned RESYNC_ONES = 32;
    localparam logic [5:0]  ONES_LAST   = 6'(RESYNC_ONES - 1);

    // Typical configuration bytes.
    localparam logic [7:0] CMD_CLOCK_WR = 8'h20;
    localparam logic [7:0] CLOCK_EX     = 8'h18;
    localparam logic [7:0] CMD_SETUP_WR = 8'h10;
    localparam logic [7:0] SETUP_EX     = 8'h40;
    localparam logic [7:0] CMD_DATA_RD  = 8'h38;

    typedef enum logic [2:0] {
        ST_CMD = 3'b001,
        ST_WR  = 3'b010,
        ST_RD  = 3'b100
    } adcsp_state_t;

    // Number of serial clocks of one access to the selected register.
    function automatic logic [4:0] reg_bits(input logic [2:0] rs);
        logic [4:0] n;
        n = BITS_BYTE;
        if (rs == RS_DATA) begin
            n = BITS_DATA;
        end else if (rs == RS_OFFS || rs == RS_GAIN) begin
            n = BITS_CAL;
        end
        return n;
    endfunction

endpackage

// ===== adcsp_ready.sv
`timescale 1ns/1ps
module adcsp_ready (
    input  wire logic sys_clk,
    input  wire logic srst,
    adcsp_if.rdy_mp   rdy
);
    import adcsp_pkg::*;

    logic ready_n_q;

    // ready flag timing
    // A fresh result wins over a read or an update warning in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ready_n_q <= 1'b1;
        end else if (rdy.result_new) begin
            ready_n_q <= 1'b0;
        end else if (rdy.data_read || rdy.update_soon) begin
            ready_n_q <= 1'b1;
        end
    end

    assign rdy.ready_n = ready_n_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    new_low_a: assert property (rdy.result_new |=> !rdy.ready_n)
        else $error("Ready line not low after a new result.");
    read_high_a: assert property (
        (rdy.data_read || rdy.update_soon) && !rdy.result_new |=> rdy.ready_n)
        else $error("Ready line not high after read or update warning.");
    ready_hold_a: assert property (
        !rdy.result_new && !rdy.data_read && !rdy.update_soon |=> $stable(rdy.ready_n))
        else $error("Ready line changed without a cause.");
endmodule

// ===== adcsp_serial_port.sv
`timescale 1ns/1ps
module adcsp_serial_port (
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    input  wire logic                          sclk_pin,
    input  wire logic                          din_pin,
    input  wire logic                          cs_n_pin,
    output logic                               dout_o,
    output logic                               dout_oe,
    output logic                               result_ready_n,
    input  wire logic                          result_new,
    input  wire logic                          update_soon,
    input  wire logic [adcsp_pkg::DATA_W-1:0]  result_word,
    output logic                               clock_halve,
    output logic                               mclk_en,
    output logic                               cal_start,
    output logic                               filter_sync,
    output logic [1:0]                         active_channel,
    output logic                               standby,
    output logic [adcsp_pkg::BYTE_W-1:0]       setup_reg,
    output logic [adcsp_pkg::BYTE_W-1:0]       clock_reg,
    output logic [adcsp_pkg::BYTE_W-1:0]       test_reg,
    output logic [adcsp_pkg::CAL_W-1:0]        offset_cal,
    output logic [adcsp_pkg::CAL_W-1:0]        gain_cal
);
    import adcsp_pkg::*;

    adcsp_if lnk();

    adcsp_state_t        state_q;
    adcsp_state_t        state_d;
    logic [4:0]          bitcnt_q;
    logic [4:0]          nbits_q;
    logic [SHIFT_W-1:0]  sh_in_q;
    logic [SHIFT_W-1:0]  sh_out_q;
    logic [SHIFT_W-1:0]  rd_word;
    logic [2:0]          rs_q;
    logic [1:0]          ch_q;
    logic                stby_q;
    logic [5:0]          ones_q;
    logic [DATA_W-1:0]   data_q;
    logic [BYTE_W-1:0]   setup_q;
    logic [BYTE_W-1:0]   clock_q;
    logic [BYTE_W-1:0]   test_q;
    logic [CAL_W-1:0]    offs_q;
    logic [CAL_W-1:0]    gain_q;
    logic                dout_q;
    logic                cal_q;
    logic                halve_ph_q;

    logic                edge_rx;
    logic                edge_tx;
    logic [SHIFT_W-1:0]  sh_in_nx;
    logic [BYTE_W-1:0]   cmd_byte;
    logic [2:0]          cmd_rs;
    logic                cmd_rd;
    logic                cmd_ok;
    logic [4:0]          cmd_nbits;
    logic                bit_last;
    logic                done;
    logic                cmd_done;
    logic                cmd_go_rd;
    logic                cmd_go_wr;
    logic                wr_done;
    logic                rd_done;
    logic                resync;
    logic                in_rd;

    // Pins are brought into the system clock before anything looks at them.
    adcsp_pin_sync u_sync (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .sclk_pin (sclk_pin),
        .din_pin  (din_pin),
        .cs_n_pin (cs_n_pin),
        .pins     (lnk.pin_mp)
    );

    assign lnk.result_new  = result_new;
    assign lnk.update_soon = update_soon;

    adcsp_ready u_rdy (
        .sys_clk (sys_clk),
        .srst    (srst),
        .rdy     (lnk.rdy_mp)
    );

    // select gating
    // With the select tied low every clock edge counts, so three wires suffice.
    // sampling edge
    // The host shifts on the falling edge and samples on the rising one.
    assign edge_rx = lnk.sclk_rise & ~lnk.cs_n_s;
    assign edge_tx = lnk.sclk_fall & ~lnk.cs_n_s;
    assign in_rd   = (state_q == ST_RD);

    assign sh_in_nx  = {sh_in_q[SHIFT_W-2:0], lnk.din_s};
    assign cmd_byte  = sh_in_nx[BYTE_W-1:0];
    assign cmd_ok    = ~cmd_byte[COMM_ZERO_BIT];
    assign cmd_rs    = cmd_byte[COMM_RS_LSB +: 3];
    assign cmd_rd    = cmd_byte[COMM_RW_BIT];
    assign cmd_nbits = reg_bits(cmd_rs);

    // Frame decode; a command byte with its top bit set is dropped.
    assign bit_last  = (bitcnt_q == nbits_q - 5'h01);
    assign done      = edge_rx & bit_last;
    assign cmd_done  = done & (state_q == ST_CMD) & cmd_ok;
    assign cmd_go_rd = cmd_done & cmd_rd;
    assign cmd_go_wr = cmd_done & ~cmd_rd & (cmd_rs != RS_COMM);
    assign wr_done   = done & (state_q == ST_WR);
    assign rd_done   = done & in_rd;

    // ones run detect
    // Counted only while the port listens, so reading back ones is harmless.
    assign resync = edge_rx & lnk.din_s & (ones_q == ONES_LAST) & ~in_rd;

    // status bit read
    // Read images are left aligned so the shifter always leaves from bit 23.
    always_comb begin
        rd_word = '0;
        case (cmd_rs)
            RS_COMM:  rd_word = {lnk.ready_n, cmd_byte[BYTE_W-2:0], 16'h0000};
            RS_SETUP: rd_word = {setup_q, 16'h0000};
            RS_CLOCK: rd_word = {clock_q, 16'h0000};
            RS_DATA:  rd_word = {data_q, 8'h00};
            RS_TEST:  rd_word = {test_q, 16'h0000};
            RS_OFFS:  rd_word = offs_q;
            RS_GAIN:  rd_word = gain_q;
            default:  rd_word = '0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        if (resync) begin
            state_d = ST_CMD;
        end else begin
            case (state_q)
                ST_CMD: begin
                    if (cmd_go_rd) begin
                        state_d = ST_RD;
                    end else if (cmd_go_wr) begin
                        state_d = ST_WR;
                    end
                end
                ST_WR: begin
                    if (done) begin
                        state_d = ST_CMD;
                    end
                end
                ST_RD: begin
                    if (done) begin
                        state_d = ST_CMD;
                    end
                end
                default: state_d = ST_CMD;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= ST_CMD;
        end else begin
            state_q <= state_d;
        end
    end

    // byte continuation
    // The counter runs across byte boundaries until the whole register moved.
    always_ff @(posedge sys_clk) begin
        if (srst || resync || done) begin
            bitcnt_q <= 5'h00;
        end else if (edge_rx) begin
            bitcnt_q <= bitcnt_q + 5'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || resync) begin
            nbits_q <= BITS_BYTE;
        end else if (cmd_go_rd || cmd_go_wr) begin
            nbits_q <= cmd_nbits;
        end else if (done) begin
            nbits_q <= BITS_BYTE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sh_in_q <= '0;
        end else if (edge_rx && !in_rd) begin
            sh_in_q <= sh_in_nx;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || in_rd || resync) begin
            ones_q <= 6'h00;
        end else if (edge_rx) begin
            ones_q <= lnk.din_s ? ones_q + 6'h01 : 6'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rs_q   <= RS_COMM;
            ch_q   <= 2'h0;
            stby_q <= 1'b0;
        end else if (cmd_done) begin
            rs_q   <= cmd_rs;
            ch_q   <= cmd_byte[COMM_CH_LSB +: 2];
            stby_q <= cmd_byte[COMM_STBY_BIT];
        end
    end

    // setup register write
    // Register contents survive a resync; only the framing starts over.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            setup_q <= SETUP_RST;
            clock_q <= CLOCK_RST;
            test_q  <= TEST_RST;
            offs_q  <= OFFS_RST;
            gain_q  <= GAIN_RST;
        end else if (wr_done) begin
            case (rs_q)
                RS_SETUP: setup_q <= cmd_byte;
                RS_CLOCK: clock_q <= cmd_byte;
                RS_TEST:  test_q  <= cmd_byte;
                RS_OFFS:  offs_q  <= sh_in_nx;
                RS_GAIN:  gain_q  <= sh_in_nx;
                default:  test_q  <= test_q;
            endcase
        end
    end

    // calibration start
    // A nonzero mode field in a setup write launches that calibration once.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cal_q <= 1'b0;
        end else begin
            cal_q <= wr_done && rs_q == RS_SETUP
                     && cmd_byte[SETUP_MODE_LSB +: 2] != MODE_NORMAL;
        end
    end

    // The result word is taken whole so a read in flight keeps its own copy.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            data_q <= DATA_RST;
        end else if (result_new) begin
            data_q <= result_word;
        end
    end

    // MSB first out
    // Bits change on the falling edge so they are settled at the host's rising edge.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sh_out_q <= '0;
            dout_q   <= 1'b1;
        end else if (cmd_go_rd) begin
            sh_out_q <= rd_word;
        end else if (edge_tx && in_rd) begin
            dout_q   <= sh_out_q[SHIFT_W-1];
            sh_out_q <= {sh_out_q[SHIFT_W-2:0], 1'b0};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            halve_ph_q <= 1'b0;
        end else begin
            halve_ph_q <= ~halve_ph_q;
        end
    end

    assign lnk.data_read = rd_done & (rs_q == RS_DATA);

    // output released
    // The enable drops with the select, so a shared pulled-up line is safe.
    assign dout_oe        = in_rd & ~lnk.cs_n_s;
    assign dout_o         = dout_q;
    assign result_ready_n = lnk.ready_n;
    assign clock_halve    = clock_q[CLK_HALVE_BIT];
    assign mclk_en        = ~clock_q[CLK_HALVE_BIT] | halve_ph_q;
    assign cal_start      = cal_q;
    assign filter_sync    = setup_q[SETUP_FILTER_SYNC_BIT];
    assign active_channel = ch_q;
    assign standby        = stby_q;
    assign setup_reg      = setup_q;
    assign clock_reg      = clock_q;
    assign test_reg       = test_q;
    assign offset_cal     = offs_q;
    assign gain_cal       = gain_q;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    reset_cmd_a: assert property (disable iff (1'b0) srst |=> state_q == ST_CMD)
        else $error("Port not awaiting a command after reset.");
    half_dup_a: assert property (state_q != ST_RD |-> !dout_oe)
        else $error("Output enabled outside a read.");
    release_a: assert property (lnk.cs_n_s |-> !dout_oe)
        else $error("Output driven while deselected.");
    rd_ignore_a: assert property (in_rd && edge_rx |=> $stable(sh_in_q) && $stable(setup_q))
        else $error("Input sampled during a read.");
    arm_wr_a: assert property (cmd_go_wr |=> state_q == ST_WR && bitcnt_q == 5'h00)
        else $error("Write not armed after command byte.");
    msb_out_a: assert property (in_rd && edge_tx |=> dout_q == $past(sh_out_q[SHIFT_W-1]))
        else $error("Read bit order wrong.");
    msb_in_a: assert property (wr_done && rs_q == RS_SETUP |=> setup_q == $past(cmd_byte))
        else $error("Setup write not stored in order.");
    cal_len_a: assert property (cmd_go_wr && cmd_rs == RS_OFFS |=> nbits_q == BITS_CAL)
        else $error("Calibration access not 24 bits.");
    multi_byte_a: assert property (state_q == ST_WR && edge_rx && bitcnt_q == 5'h07
        && nbits_q == BITS_CAL |=> state_q == ST_WR)
        else $error("Wide write ended at a byte boundary.");
    status_bit_a: assert property (cmd_go_rd && cmd_rs == RS_COMM
        |=> sh_out_q[SHIFT_W-1] == $past(lnk.ready_n))
        else $error("Status bit missing from command readback.");
    halve_a: assert property (clock_halve && mclk_en && !(wr_done && rs_q == RS_CLOCK)
        |=> !mclk_en)
        else $error("Master clock enable not halved.");
    cmd_clock_a: assert property (cmd_done && cmd_byte == CMD_CLOCK_WR
        |=> state_q == ST_WR && rs_q == RS_CLOCK && ch_q == 2'h0)
        else $error("Clock write not armed.");
    clock_ex_a: assert property (wr_done && rs_q == RS_CLOCK && cmd_byte == CLOCK_EX
        |=> clock_halve)
        else $error("Clock byte did not set halving.");
    cmd_setup_a: assert property (cmd_done && cmd_byte == CMD_SETUP_WR
        |=> state_q == ST_WR && rs_q == RS_SETUP)
        else $error("Setup write not armed.");
    setup_ex_a: assert property (wr_done && rs_q == RS_SETUP && cmd_byte == SETUP_EX
        |=> cal_start ##1 !cal_start && !filter_sync)
        else $error("Setup byte did not start calibration.");
    cmd_data_a: assert property (cmd_done && cmd_byte == CMD_DATA_RD
        |=> state_q == ST_RD && nbits_q == BITS_DATA)
        else $error("Result read not armed for 16 bits.");
    resync_a: assert property (resync |=> state_q == ST_CMD && bitcnt_q == 5'h00
        && $stable(setup_q))
        else $error("Resync did not restore command state.");
    read_done_a: assert property (rd_done && rs_q == RS_DATA && !result_new
        |=> result_ready_n)
        else $error("Ready line not released after result read.");

    cov_data_rd: cover property (rd_done && rs_q == RS_DATA);
    cov_setup_wr: cover property (wr_done && rs_q == RS_SETUP);
    cov_cal_wr: cover property (wr_done && rs_q == RS_GAIN);
    cov_resync: cover property (resync);
endmodule
